// file: hdl/ebct_bus_cycle.sv
`timescale 1ns/100ps

// What this block does
// - Demux normal latch: 4 plus waitstates
// - Demux extended or mux normal: 6 plus waits
// - Mux extended latch: 8 plus waitstates
// - Latch length and two waitstate kinds programmable
// - Delay bit places strobe falling edges
// - Early-write bit places write rising edge
// - Waitstates or ready-inactive extend strobe phase
// - Tristate wait added after strobe ends
// - Read data captured when strobe rises
// - Address stable until write strobe high
// - Reference clock period is two half periods
// - Mux mode shares port for address, data
// - Ready high waits, ready low terminates
// - Mux cycles append one multiplexing waitstate
module ebct_bus_cycle
  import ebct_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        req_write_i,
  input  wire logic [23:0] req_addr_i,
  input  wire logic [15:0] req_wdata_i,
  input  wire logic [1:0]  req_be_i,
  input  wire logic        cfg_mux_i,
  input  wire logic        cfg_ext_ale_i,
  input  wire logic [3:0]  cfg_mctc_i,
  input  wire logic        cfg_mttc_i,
  input  wire logic        rw_delay_bit_i,
  input  wire logic        early_write_bit_i,
  input  wire logic        cfg_ready_en_i,
  input  wire logic        ready_n_i,
  input  wire logic [15:0] shared_addr_data_port_i,
  output logic             req_ready_o,
  output logic             done_o,
  output logic      [15:0] rdata_o,
  output logic      [23:0] addr_o,
  output logic             ale_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic             write_low_byte_strobe_n_o,
  output logic             write_high_byte_strobe_n_o,
  output logic             write_chip_select_n_o,
  output logic             read_chip_select_n_o,
  output logic             cs_n_o,
  output logic             byte_high_enable_n_o,
  output logic      [15:0] shared_addr_data_port_o,
  output logic             shared_addr_data_port_oe_n_o,
  output logic             reference_clock_out_o
);

  import ebct_pkg::*;

  ebct_state_t state_reg, state_next;
  logic        mux_reg, mux_next, ext_reg, ext_next, tri_reg, tri_next;
  logic        rwdc_reg, rwdc_next, ewen_reg, ewen_next, rdy_reg, rdy_next;
  logic        write_reg, write_next, lead_reg, lead_next;
  logic [1:0]  be_reg, be_next;
  logic [5:0]  cmd_len_reg, cmd_len_next;
  logic [23:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic        refclk_reg, refclk_next;
  logic        load;
  logic [5:0]  load_val;
  logic        expired, cycle_end, ready_wait, in_cycle, strobe_on, drive;

  // ==========================================================================
  // Phase timer
  // ==========================================================================
  ebct_tcl_timer u_timer (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (load),
    .load_val_i (load_val),
    .count_o    (),
    .expired_o  (expired)
  );

  // Ready is looked at only in the last half period of the strobe phase
  assign ready_wait = (state_reg == EBCT_CMD) && expired && rdy_reg && ready_n_i;
  assign cycle_end  = ((state_reg == EBCT_HOLD) && expired && !tri_reg) ||
                      ((state_reg == EBCT_TRIS) && expired);

  // ==========================================================================
  // Sequencer: next state and captured cycle attributes
  // ==========================================================================
  always_comb begin
    state_next   = state_reg;
    mux_next     = mux_reg;
    ext_next     = ext_reg;
    tri_next     = tri_reg;
    rwdc_next    = rwdc_reg;
    ewen_next    = ewen_reg;
    rdy_next     = rdy_reg;
    write_next   = write_reg;
    be_next      = be_reg;
    cmd_len_next = cmd_len_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    rdata_next   = rdata_reg;
    load         = 1'b0;
    load_val     = 6'h00;
    // Configuration is frozen at acceptance so a mid-cycle change is harmless
    case (state_reg)
      EBCT_IDLE: begin
        if (req_i) begin
          mux_next     = cfg_mux_i;
          ext_next     = cfg_ext_ale_i;
          tri_next     = !cfg_mttc_i;
          rwdc_next    = rw_delay_bit_i;
          ewen_next    = early_write_bit_i;
          rdy_next     = cfg_ready_en_i;
          write_next   = req_write_i;
          be_next      = req_be_i;
          addr_next    = req_addr_i;
          wdata_next   = req_wdata_i;
          cmd_len_next = LEN_CMD_BASE + ebct_wait_len(cfg_mctc_i);
          state_next   = EBCT_ADDR;
          load         = 1'b1;
          load_val     = (cfg_ext_ale_i ? LEN_ADDR_EXT : LEN_ADDR_NORM) - 6'h01;
        end
      end
      EBCT_ADDR: begin
        if (expired) begin
          load = 1'b1;
          if (mux_reg) begin
            state_next = EBCT_MUXA;
            load_val   = LEN_MUX_ADDR - 6'h01;
          end else begin
            state_next = EBCT_CMD;
            load_val   = cmd_len_reg - 6'h01;
          end
        end
      end
      EBCT_MUXA: begin
        if (expired) begin
          state_next = EBCT_CMD;
          load       = 1'b1;
          load_val   = cmd_len_reg - 6'h01;
        end
      end
      EBCT_CMD: begin
        if (ready_wait) begin
          load     = 1'b1;
          load_val = LEN_WAIT - 6'h01;
        end else if (expired) begin
          if (!write_reg) begin
            rdata_next = shared_addr_data_port_i;
          end
          state_next = EBCT_HOLD;
          load       = 1'b1;
          load_val   = LEN_HOLD - 6'h01;
        end
      end
      EBCT_HOLD: begin
        if (expired && tri_reg) begin
          state_next = EBCT_TRIS;
          load       = 1'b1;
          load_val   = LEN_TRIS - 6'h01;
        end
      end
      EBCT_TRIS, EBCT_MUXW: begin
      end
      default: begin
        state_next = EBCT_IDLE;
      end
    endcase
    if (cycle_end) begin
      if (mux_reg) begin
        state_next = EBCT_MUXW;
        load       = 1'b1;
        load_val   = LEN_MUX_WAIT - 6'h01;
      end else begin
        state_next = EBCT_IDLE;
      end
    end
    if ((state_reg == EBCT_MUXW) && expired) begin
      state_next = EBCT_IDLE;
    end
    lead_next   = (state_next == EBCT_CMD) && (state_reg != EBCT_CMD);
    refclk_next = !refclk_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= EBCT_IDLE;
      mux_reg     <= 1'b0;
      ext_reg     <= 1'b0;
      tri_reg     <= 1'b0;
      rwdc_reg    <= 1'b0;
      ewen_reg    <= 1'b0;
      rdy_reg     <= 1'b0;
      write_reg   <= 1'b0;
      lead_reg    <= 1'b0;
      be_reg      <= 2'h0;
      cmd_len_reg <= LEN_CMD_BASE;
      addr_reg    <= 24'h000000;
      wdata_reg   <= 16'h0000;
      rdata_reg   <= 16'h0000;
      refclk_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      mux_reg     <= mux_next;
      ext_reg     <= ext_next;
      tri_reg     <= tri_next;
      rwdc_reg    <= rwdc_next;
      ewen_reg    <= ewen_next;
      rdy_reg     <= rdy_next;
      write_reg   <= write_next;
      lead_reg    <= lead_next;
      be_reg      <= be_next;
      cmd_len_reg <= cmd_len_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      rdata_reg   <= rdata_next;
      refclk_reg  <= refclk_next;
    end
  end

  // ==========================================================================
  // Pin decode
  // ==========================================================================
  // Delayed strobes skip the first half period of the strobe phase
  assign in_cycle  = (state_reg != EBCT_IDLE) && (state_reg != EBCT_MUXW);
  assign strobe_on = (state_reg == EBCT_CMD) && (rwdc_reg || !lead_reg);
  assign rd_n_o    = !(strobe_on && !write_reg);
  // Early write gives up the last half period for extra data hold
  assign wr_n_o    = !(strobe_on && write_reg &&
                       !(ewen_reg && expired && !ready_wait));
  assign write_low_byte_strobe_n_o  = wr_n_o || !be_reg[0];
  assign write_high_byte_strobe_n_o = wr_n_o || !be_reg[1];
  assign write_chip_select_n_o      = wr_n_o;
  assign read_chip_select_n_o       = rd_n_o;
  assign cs_n_o               = !in_cycle;
  assign byte_high_enable_n_o = !(in_cycle && be_reg[1]);
  assign ale_o                = (state_reg == EBCT_ADDR);
  assign addr_o               = addr_reg;
  assign rdata_o              = rdata_reg;
  assign req_ready_o          = (state_reg == EBCT_IDLE);
  assign done_o               = cycle_end;
  assign reference_clock_out_o = refclk_reg;

  // Mux mode puts the address out first; data follows on the same lines
  always_comb begin
    drive                   = 1'b0;
    shared_addr_data_port_o = wdata_reg;
    if (mux_reg && ((state_reg == EBCT_ADDR) || (state_reg == EBCT_MUXA))) begin
      drive                   = 1'b1;
      shared_addr_data_port_o = addr_reg[15:0];
    end else if (write_reg && in_cycle && (state_reg != EBCT_TRIS)) begin
      drive = 1'b1;
    end
  end
  assign shared_addr_data_port_oe_n_o = !drive;

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic [7:0] cyc_cnt_reg, ext_cnt_reg, exp_len;
  always_ff @(posedge clk_i) begin
    if (rst_i || (state_reg == EBCT_IDLE) || (state_reg == EBCT_MUXW)) begin
      cyc_cnt_reg <= 8'h00;
      ext_cnt_reg <= 8'h00;
    end else begin
      cyc_cnt_reg <= cyc_cnt_reg + 8'h01;
      ext_cnt_reg <= ext_cnt_reg + (ready_wait ? 8'h02 : 8'h00);
    end
  end
  assign exp_len = 8'(cmd_len_reg - LEN_CMD_BASE) + (tri_reg ? 8'h02 : 8'h00) + ext_cnt_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cmd_start;
    (state_reg != EBCT_CMD) ##1 (state_reg == EBCT_CMD);
  endsequence
  sequence s_rd_late;
    rd_n_o ##1 !rd_n_o;
  endsequence

  property p_len_demux_norm;
    (cycle_end && !mux_reg && !ext_reg) |-> (cyc_cnt_reg + 8'h01 == DUR_DEMUX_NORM + exp_len);
  endproperty
  a_len_demux_norm: assert property (p_len_demux_norm) else $error("demux normal length");

  property p_len_mid;
    (cycle_end && (mux_reg != ext_reg)) |-> (cyc_cnt_reg + 8'h01 == DUR_MID + exp_len);
  endproperty
  a_len_mid: assert property (p_len_mid) else $error("six half period cycle length");

  property p_len_mux_ext;
    (cycle_end && mux_reg && ext_reg) |-> (cyc_cnt_reg + 8'h01 == DUR_MUX_EXT + exp_len);
  endproperty
  a_len_mux_ext: assert property (p_len_mux_ext) else $error("mux extended length");

  property p_rd_delay;
    (s_cmd_start ##0 (!rwdc_reg && !write_reg)) |-> s_rd_late;
  endproperty
  a_rd_delay: assert property (p_rd_delay) else $error("delayed read edge wrong");

  property p_early_write;
    ((state_reg == EBCT_CMD) && ewen_reg && expired && !ready_wait) |-> wr_n_o;
  endproperty
  a_early_write: assert property (p_early_write) else $error("early write still low");

  property p_ready_wait;
    ready_wait |=> (state_reg == EBCT_CMD) [*2];
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready wait not inserted");

  property p_tristate;
    ((state_reg == EBCT_HOLD) && expired && tri_reg) |=> (rd_n_o && wr_n_o) [*2];
  endproperty
  a_tristate: assert property (p_tristate) else $error("tristate wait lost");

  property p_rdata;
    ($fell(state_reg == EBCT_CMD) && !write_reg) |-> (rdata_o == $past(shared_addr_data_port_i));
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data not captured");

  property p_addr_stable;
    (!wr_n_o ##1 1'b1) |-> $stable(addr_o);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved under write");

  property p_refclk;
    reference_clock_out_o |=> !reference_clock_out_o ##1 reference_clock_out_o;
  endproperty
  a_refclk: assert property (p_refclk) else $error("reference clock period wrong");

  property p_mux_wait;
    (cycle_end && mux_reg) |=> ((state_reg == EBCT_MUXW) && !req_ready_o) [*2];
  endproperty
  a_mux_wait: assert property (p_mux_wait) else $error("mux waitstate missing");

  property p_mux_addr;
    (mux_reg && ale_o) |-> (!shared_addr_data_port_oe_n_o &&
                            (shared_addr_data_port_o == addr_reg[15:0]));
  endproperty
  a_mux_addr: assert property (p_mux_addr) else $error("shared port lacks address");

endmodule // ebct_bus_cycle

// file: hdl/ebct_pkg.sv
package ebct_pkg;

  // ==========================================================================
  // Timing base: one half clock period per system clock
  // ==========================================================================
  localparam int          CLK_PERIOD_PS  = 25000;
  localparam int          HALF_CLK_PS    = 25000;
  localparam int          HALF_CLK_CYC   = (HALF_CLK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          CNT_W          = 6;

  // ==========================================================================
  // Phase lengths, counted in half clock periods
  // ==========================================================================
  localparam logic [5:0]  LEN_ADDR_NORM  = 6'h01;
  localparam logic [5:0]  LEN_ADDR_EXT   = 6'h03;
  localparam logic [5:0]  LEN_MUX_ADDR   = 6'h02;
  localparam logic [5:0]  LEN_CMD_BASE   = 6'h02;
  localparam logic [5:0]  LEN_WAIT       = 6'h02;
  localparam logic [5:0]  LEN_HOLD       = 6'h01;
  localparam logic [5:0]  LEN_TRIS       = 6'h02;
  localparam logic [5:0]  LEN_MUX_WAIT   = 6'h02;
  localparam logic [3:0]  MCTC_NO_WAIT   = 4'hf;

  // Whole cycle durations without any waitstate
  localparam logic [7:0]  DUR_DEMUX_NORM = 8'h04;
  localparam logic [7:0]  DUR_MID        = 8'h06;
  localparam logic [7:0]  DUR_MUX_EXT    = 8'h08;

  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  typedef enum logic [2:0] {
    EBCT_IDLE = 3'b000,
    EBCT_ADDR = 3'b001,
    EBCT_MUXA = 3'b010,
    EBCT_CMD  = 3'b011,
    EBCT_HOLD = 3'b100,
    EBCT_TRIS = 3'b101,
    EBCT_MUXW = 3'b110
  } ebct_state_t;

  // Inverted waitstate field to half periods: 2 per waitstate
  function automatic logic [5:0] ebct_wait_len(input logic [3:0] mctc);
    logic [3:0] ws;
    ws = MCTC_NO_WAIT - mctc;
    return {1'b0, ws, 1'b0};
  endfunction

endpackage

// file: hdl/ebct_tcl_timer.sv
`timescale 1ns/100ps

// ============================================================================
// Phase timer: loads a length minus one and counts half periods down
// ============================================================================
module ebct_tcl_timer
  import ebct_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] load_val_i,
  output logic      [CNT_W-1:0] count_o,
  output logic                  expired_o
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  // Saturate at zero so an idle timer reads as expired
  always_comb begin
    if (load_i) begin
      count_next = load_val_i;
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
    end else begin
      count_next = count_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count_o   = count_reg;
  assign expired_o = (count_reg == '0);

endmodule // ebct_tcl_timer

// file: tb/ebct_mem_model.sv
`timescale 1ns/100ps

// ============================================================================
// Far-side memory: 16 words, byte lanes, ready-controlled answers
// ============================================================================
module ebct_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [23:0] addr_i,
  input  wire logic        cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_lo_n_i,
  input  wire logic        wr_hi_n_i,
  input  wire logic [15:0] data_i,
  input  wire logic        data_oe_n_i,
  input  wire logic [2:0]  waits_i,
  output logic      [15:0] data_o,
  output logic             ready_n_o
);
  logic [15:0] mem [16];
  logic [15:0] last_reg;
  logic [4:0]  strobe_cnt_reg;
  logic        active;

  // A command strobe is live only while the device is selected
  assign active = !cs_n_i && (!rd_n_i || !wr_lo_n_i || !wr_hi_n_i);

  // Byte lanes follow their strobe; the last beat before the rise wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 16'ha500 | 16'(i);
      end
      strobe_cnt_reg <= 5'h00;
      last_reg       <= 16'h0000;
    end else begin
      strobe_cnt_reg <= active ? strobe_cnt_reg + 5'h01 : 5'h00;
      if (!cs_n_i && !wr_lo_n_i && !data_oe_n_i) begin
        mem[addr_i[3:0]][7:0] <= data_i[7:0];
      end
      if (!cs_n_i && !wr_hi_n_i && !data_oe_n_i) begin
        mem[addr_i[3:0]][15:8] <= data_i[15:8];
      end
      if (!cs_n_i && !rd_n_i) begin
        last_reg <= mem[addr_i[3:0]];
      end
    end
  end

  // Released bus shows the inverse of the last word, so stale data never matches
  assign data_o = (!cs_n_i && !rd_n_i) ? mem[addr_i[3:0]] : ~last_reg;

  // Not ready for the first 2*waits strobe clocks; pulled up when idle.
  // Keyed to select and a registered count: the early write strobe depends on ready,
  // so keying ready to the strobes themselves would close a combinational loop
  assign ready_n_o = !cs_n_i ? (strobe_cnt_reg < {1'b0, waits_i, 1'b0}) : 1'b1;

endmodule // ebct_mem_model

// file: tb/tb_external_bus_cycle_timing.sv
`timescale 1ns/100ps

// ============================================================================
// Bench: bus cycles of every mode, checked for length, strobe edges and data
// ============================================================================
module tb_external_bus_cycle_timing;
  import ebct_pkg::*;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req_i = 1'b0;
  logic        req_write_i = 1'b0;
  logic [23:0] req_addr_i = 24'h000000;
  logic [15:0] req_wdata_i = 16'h0000;
  logic [1:0]  req_be_i = 2'h3;
  logic        cfg_mux_i = 1'b0;
  logic        cfg_ext_ale_i = 1'b0;
  logic [3:0]  cfg_mctc_i = 4'hf;
  logic        cfg_mttc_i = 1'b1;
  logic        rw_delay_bit_i = 1'b1;
  logic        early_write_bit_i = 1'b0;
  logic        cfg_ready_en_i = 1'b0;
  logic [2:0]  mdl_waits = 3'h0;
  logic        ready_n, req_ready_o, done_o, ale_o, rd_n_o, wr_n_o, cs_n_o, bhe_n;
  logic        wrl_n, wrh_n, wcs_n, rcs_n, port_oe_n, reference_clock_out_o;
  logic [15:0] port_in, rdata_o, port_out;
  logic [23:0] addr_o;
  logic [15:0] shadow [16];
  int          mismatches = 0;
  int          total_checks = 0;

  always #12.5 clk_i = ~clk_i;

  ebct_bus_cycle u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_be_i(req_be_i),
    .cfg_mux_i(cfg_mux_i), .cfg_ext_ale_i(cfg_ext_ale_i), .cfg_mctc_i(cfg_mctc_i),
    .cfg_mttc_i(cfg_mttc_i), .rw_delay_bit_i(rw_delay_bit_i),
    .early_write_bit_i(early_write_bit_i), .cfg_ready_en_i(cfg_ready_en_i),
    .ready_n_i(ready_n), .shared_addr_data_port_i(port_in), .req_ready_o(req_ready_o),
    .done_o(done_o), .rdata_o(rdata_o), .addr_o(addr_o), .ale_o(ale_o), .rd_n_o(rd_n_o),
    .wr_n_o(wr_n_o), .write_low_byte_strobe_n_o(wrl_n), .write_high_byte_strobe_n_o(wrh_n),
    .write_chip_select_n_o(wcs_n), .read_chip_select_n_o(rcs_n), .cs_n_o(cs_n_o),
    .byte_high_enable_n_o(bhe_n), .shared_addr_data_port_o(port_out),
    .shared_addr_data_port_oe_n_o(port_oe_n), .reference_clock_out_o(reference_clock_out_o)
  );

  ebct_mem_model u_mem (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_o), .cs_n_i(cs_n_o), .rd_n_i(rd_n_o),
    .wr_lo_n_i(wrl_n), .wr_hi_n_i(wrh_n), .data_i(port_out), .data_oe_n_i(port_oe_n),
    .waits_i(mdl_waits), .data_o(port_in), .ready_n_o(ready_n)
  );

  // ==========================================================================
  // Comparison and verdict
  // ==========================================================================
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================================
  // One bus cycle: request, watch every clock, then compare against the rules
  // ==========================================================================
  task automatic cyc(input logic wr, input logic [23:0] a, input logic [15:0] d,
                     input logic [1:0] be, input logic mx, input logic ex,
                     input logic [3:0] mc, input logic mt, input logic rw, input logic ew,
                     input logic rdy, input logic [2:0] w);
    int   k, first, lastk, s0, ww, m, g;
    logic sa, sd, moved, bad_lane, bad_pin, strobe_n;
    k = 0;
    first = 0;
    lastk = 0;
    sa = 1'b0;
    sd = 1'b0;
    moved = 1'b0;
    bad_lane = 1'b0;
    bad_pin = 1'b0;
    ww = rdy ? int'(w) : 0;
    m = 15 - int'(mc);
    @(posedge clk_i);
    req_i <= 1'b1;
    {req_write_i, req_addr_i, req_wdata_i, req_be_i, mdl_waits} <= {wr, a, d, be, w};
    {cfg_mux_i, cfg_ext_ale_i, cfg_mctc_i, cfg_mttc_i} <= {mx, ex, mc, mt};
    {rw_delay_bit_i, early_write_bit_i, cfg_ready_en_i} <= {rw, ew, rdy};
    // Strobe, address and port activity sampled once settled in each clock
    do begin
      @(posedge clk_i);
      req_i <= 1'b0;
      #1;
      k++;
      strobe_n = wr ? wr_n_o : rd_n_o;
      if (strobe_n === 1'b0 && first == 0) first = k;
      if (strobe_n === 1'b0) lastk = k;
      if (addr_o !== a) moved = 1'b1;
      if (port_oe_n === 1'b0 && port_out === a[15:0]) sa = 1'b1;
      if (wr_n_o === 1'b0 && port_oe_n === 1'b0 && port_out === d) sd = 1'b1;
      if ({wrh_n, wrl_n} !== ({2{wr_n_o}} | ~be)) bad_lane = 1'b1;
      // Latch strobe only in the latch phase; select, byte-high and chip selects follow
      if (ale_o !== (k <= (ex ? 3 : 1)) || cs_n_o !== 1'b0) bad_pin = 1'b1;
      if (wcs_n !== wr_n_o || rcs_n !== rd_n_o || bhe_n !== !be[1]) bad_pin = 1'b1;
    end while (done_o !== 1'b1 && k < 80);
    s0 = 2 + (ex ? 2 : 0) + (mx ? 2 : 0);
    check("cycle_len", k, 4 + (mx ? 2 : 0) + (ex ? 2 : 0) + 2*m + (mt ? 0 : 2) + 2*ww);
    check("strobe_fall", first, s0 + (rw ? 0 : 1));
    check("strobe_rise", lastk, s0 + 1 + 2*m + 2*ww - ((wr && ew) ? 1 : 0));
    check("addr_held", moved, 1'b0);
    check("port_addr", sa, mx);
    check("byte_lanes", bad_lane, 1'b0);
    check("pins", bad_pin, 1'b0);
    if (wr) begin
      check("port_data", sd, 1'b1);
      if (be[0]) shadow[a[3:0]][7:0] = d[7:0];
      if (be[1]) shadow[a[3:0]][15:8] = d[15:8];
    end else begin
      check("rdata", rdata_o, shadow[a[3:0]]);
    end
    // Idle again one clock after done, or three with the multiplexing wait
    g = 0;
    do begin
      @(posedge clk_i);
      #1;
      g++;
    end while (req_ready_o !== 1'b1 && g < 10);
    check("gap", g, mx ? 3 : 1);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic prev;
    for (int i = 0; i < 16; i++) shadow[i] = 16'ha500 | 16'(i);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check("idle_ready", req_ready_o, 1'b1);
    check("idle_cs", {cs_n_o, rd_n_o, wr_n_o, port_oe_n}, 4'hf);
    // Reference clock flips every half period
    for (int i = 0; i < 4; i++) begin
      prev = reference_clock_out_o;
      @(posedge clk_i);
      #1;
      check("refclk", reference_clock_out_o, !prev);
    end
    //  wr    addr        data      be    mx    ex    mctc  mttc  rw    ew    rdy   waits
    cyc(1'b1, 24'h012303, 16'h1234, 2'h3, 1'b0, 1'b0, 4'hf, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0);
    cyc(1'b0, 24'h012303, 16'h0000, 2'h3, 1'b0, 1'b0, 4'hf, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0);
    cyc(1'b1, 24'h00a005, 16'h5a3c, 2'h1, 1'b0, 1'b1, 4'he, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
    cyc(1'b0, 24'h00a005, 16'h0000, 2'h3, 1'b1, 1'b0, 4'hd, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0);
    cyc(1'b1, 24'h3c0009, 16'hc3e1, 2'h2, 1'b1, 1'b1, 4'hf, 1'b1, 1'b1, 1'b1, 1'b0, 3'h0);
    cyc(1'b0, 24'h3c0009, 16'h0000, 2'h3, 1'b1, 1'b1, 4'hf, 1'b0, 1'b1, 1'b0, 1'b1, 3'h2);
    cyc(1'b0, 24'h000007, 16'h0000, 2'h3, 1'b0, 1'b0, 4'hf, 1'b1, 1'b0, 1'b0, 1'b1, 3'h0);
    cyc(1'b0, 24'h00000c, 16'h0000, 2'h3, 1'b0, 1'b1, 4'hf, 1'b1, 1'b0, 1'b0, 1'b1, 3'h1);
    cyc(1'b1, 24'h00000c, 16'h9876, 2'h3, 1'b0, 1'b0, 4'hc, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0);
    give_verdict();
  end

  // Watchdog: the whole sequence needs about a hundred clocks
  initial begin
    #(25 * 3000);
    mismatches++;
    give_verdict();
  end

endmodule // tb_external_bus_cycle_timing
